/* common/bank_cmd_if.sv */
// command carrier between the decoder and one bank tracker
`default_nettype none
interface bank_cmd_if;
  import ddr2_cmd_pkg::*;
  logic        tick;
  logic        valid;
  cmd_t        cmd;
  logic        ap;
  logic [13:0] row;
  logic [2:0]  wl;
  logic [2:0]  bl_half;
  logic        legal;
  bank_state_t state;
  logic [13:0] row_q;

  modport ctrl (output tick, valid, cmd, ap, row, wl, bl_half, input legal, state, row_q);
  modport bank (input tick, valid, cmd, ap, row, wl, bl_half, output legal, state, row_q);
endinterface
`default_nettype wire

/* common/ddr2_cmd_pkg.sv */
// shared types of the command interpreter
`default_nettype none
package ddr2_cmd_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACT = 3'b001,
    CMD_RD  = 3'b010,
    CMD_WR  = 3'b011,
    CMD_PRE = 3'b100,
    CMD_REF = 3'b101,
    CMD_MRS = 3'b110,
    CMD_DES = 3'b111
  } cmd_t;

  typedef enum logic [2:0] {
    BK_IDLE  = 3'b000,
    BK_ACTV  = 3'b001,
    BK_OPEN  = 3'b010,
    BK_READ  = 3'b011,
    BK_WRITE = 3'b100,
    BK_RDAP  = 3'b101,
    BK_WRAP  = 3'b110,
    BK_PRE   = 3'b111
  } bank_state_t;

  typedef enum logic [1:0] {
    AP_NONE = 2'b00,
    AP_RD   = 2'b01,
    AP_WR   = 2'b10
  } ap_kind_t;
endpackage
`default_nettype wire

/* common/ddr2_cmd_regs.svh */
// timing counts, field positions and reset values of the command interpreter
`ifndef DDR2_CMD_REGS_SVH
`define DDR2_CMD_REGS_SVH

// spacings are counted in link clock edges
`define RCD_CK    6'h03
`define RP_CK     6'h03
`define WR_CK     6'h03
`define WTR_CK    6'h02
`define MRD_CK    6'h02
`define AP2WR_EXTRA 6'h02

// mode register 0 fields on the address inputs
`define BL_LSB    0
`define BL_MSB    2
`define CL_LSB    4
`define CL_MSB    6
`define AP_BIT    10
`define BL8_CODE  3'h3
`define MR_RST    14'h0032

`endif

/* rtl/bank_tracker.sv */
// state and delay counter of one bank
`include "ddr2_cmd_regs.svh"
`default_nettype none
module bank_tracker
  import ddr2_cmd_pkg::*;
(
  input  wire logic   clk_sys_in,
  input  wire logic   sys_rst_in,
  bank_cmd_if.bank    bif
);
  bank_state_t state_q;
  logic [5:0]  cnt_q;
  logic [13:0] row_q;

  assign bif.state = state_q;
  assign bif.row_q = row_q;

  // what this bank's own state permits; activate and auto-precharge phases refuse same-bank commands, precharge phase takes only precharge
  always_comb
  begin
    case (bif.cmd)
      CMD_ACT: bif.legal = (state_q == BK_IDLE);
      CMD_RD,
      CMD_WR:  bif.legal = (state_q == BK_OPEN) || (state_q == BK_READ) || (state_q == BK_WRITE);
      CMD_PRE: bif.legal = (state_q == BK_IDLE) || (state_q == BK_OPEN) || (state_q == BK_READ)
                           || (state_q == BK_WRITE) || (state_q == BK_PRE);
      default: bif.legal = 1'b0;
    endcase
  end

  // state walk; each timed phase ends when its counter runs out on a link edge, a read or write phase also on an accepted same-bank command
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= BK_IDLE;
      cnt_q   <= 6'h00;
    end
    else if (bif.tick && bif.valid && bif.legal)
    begin
      case (bif.cmd)
        CMD_ACT:
        begin
          state_q <= BK_ACTV;                                              // see R09
          cnt_q   <= `RCD_CK;
        end
        CMD_RD:
        begin
          state_q <= bif.ap ? BK_RDAP : BK_READ;                           // see R24
          cnt_q   <= {3'h0, bif.bl_half};                                  // see R13
        end
        CMD_WR:
        begin
          state_q <= bif.ap ? BK_WRAP : BK_WRITE;                          // see R24
          cnt_q   <= {3'h0, bif.wl} + {3'h0, bif.bl_half} + (bif.ap ? `WR_CK : 6'h00); // see R14
        end
        CMD_PRE:
        begin
          if (state_q != BK_IDLE)
          begin
            state_q <= BK_PRE;                                             // see R08
            cnt_q   <= `RP_CK;
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
    else if (bif.tick && cnt_q != 6'h00)
    begin
      cnt_q <= cnt_q - 6'h01;
      if (cnt_q == 6'h01)
      begin
        case (state_q)
          BK_ACTV, BK_READ, BK_WRITE: state_q <= BK_OPEN;                  // see R09
          BK_RDAP, BK_WRAP:                                                // see R13 R14
          begin
            state_q <= BK_PRE;
            cnt_q   <= `RP_CK;
          end
          BK_PRE:  state_q <= BK_IDLE;                                     // see R08
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // open row kept until the next activate; precharge leaves it in place
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      row_q <= 14'h0000;
    else if (bif.tick && bif.valid && bif.legal && bif.cmd == CMD_ACT)
      row_q <= bif.row;                                                    // see R21
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_row_latched: assert property (bif.tick && bif.valid && bif.legal && bif.cmd == CMD_ACT // see R21
    |=> row_q == $past(bif.row) && state_q == BK_ACTV)
    else $error("activate did not open the given row");
  a_ap_select: assert property (bif.tick && bif.valid && bif.legal && bif.cmd == CMD_RD && bif.ap // see R24
    |=> state_q == BK_RDAP)
    else $error("read with auto precharge not tracked");
  a_rdap_precharge: assert property (state_q == BK_RDAP && bif.tick && cnt_q == 6'h01 // see R13
    |=> state_q == BK_PRE && cnt_q == `RP_CK)
    else $error("read auto precharge did not start");
  a_wrap_recovery: assert property (state_q == BK_WRAP && bif.tick && cnt_q == 6'h01 // see R14
    |=> state_q == BK_PRE)
    else $error("write auto precharge did not start");
  a_idle_after_pre: assert property (state_q == BK_PRE && bif.tick && cnt_q == 6'h01 && !bif.valid // see R08
    |=> state_q == BK_IDLE)
    else $error("bank not idle after precharge time");
  c_rdap_seen: cover property (state_q == BK_RDAP ##[1:40] state_q == BK_IDLE);
endmodule // bank_tracker
`default_nettype wire

/* rtl/ddr2_cmd_interp.sv */
// command decoder and inter-bank scheduler of a four-bank ddr2 device
`include "ddr2_cmd_regs.svh"
`default_nettype none
// What this block does
// R01 - decode commands from select, ras, cas, we and cke at rising link clock
// R02 - select high ignores new commands; ongoing operations continue
// R03 - nop registers nothing and disturbs nothing
// R04 - decode activate, read, write and precharge from ras, cas, we levels
// R05 - accept commands only when cke was high on previous and current edge
// R06 - while another bank is idle, accept whatever this bank permits
// R07 - with another bank busy, accept activate/read/write/precharge the target allows
// R08 - bank idle after precharge time elapsed and bursts finished
// R09 - bank row-active after activate-to-access delay with no burst running
// R10 - controller writes during another bank's read only after burst ends
// R11 - controller waits max of two or write-to-read delay before read
// R12 - refresh and mode load only with all banks idle
// R13 - read auto precharge starts at earliest legal explicit precharge point
// R14 - write auto precharge starts when write recovery ends
// R15 - during auto precharge accept other-bank commands not disturbing transfers
// R16 - read after write-ap waits latency minus one, half burst, write-to-read
// R17 - write after write-ap waits half burst; after read-ap half burst plus two
// R18 - read after read-ap waits half burst; precharge or activate one clock
// R19 - mode load: bank inputs pick the register, address supplies contents
// R20 - no executable command until mode-register set delay has elapsed
// R21 - activate opens the given row in the given bank until precharged
// R22 - controller precharges before opening another row in the same bank
// R23 - unlisted states and sequences are illegal
// R24 - address bit ten selects auto precharge on read or write
// R25 - per-bank state and counters check every command; spacing is checked only after auto precharge and mode load
module ddr2_cmd_interp
  import ddr2_cmd_pkg::*;
(
  input  wire logic                      clk_sys_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      ddr_ck_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      ras_n_in,
  input  wire logic                      cas_n_in,
  input  wire logic                      we_n_in,
  input  wire logic                      cke_in,
  input  wire logic [1:0]                ba_in,
  input  wire logic [13:0]               addr_in,
  output var  ddr2_cmd_pkg::cmd_t        cmd_code_out,
  output logic                           cmd_accept_out,
  output logic                           cmd_reject_out,
  output logic [1:0]                     cmd_bank_out,
  output logic                           mr_wr_out,
  output logic [1:0]                     mr_sel_out,
  output logic [13:0]                    mr_data_out,
  output logic [11:0]                    bank_state_out,
  output logic [55:0]                    bank_row_out
);
  import ddr2_cmd_pkg::*;

  logic [20:0] pin_s1_q;
  logic [20:0] pin_s2_q;
  logic        ck_s3_q;
  logic        tick;
  logic        cke_prev_q;
  logic        cs_n;
  logic        cke;
  logic [2:0]  rcw;
  logic [1:0]  ba;
  logic [13:0] addr;
  cmd_t        cmd;
  logic [13:0] mr_q [4];
  logic [2:0]  wl;
  logic [2:0]  bl_half;
  ap_kind_t    ap_kind_q;
  logic [1:0]  ap_bank_q;
  logic [5:0]  ap_cnt_q;
  logic [5:0]  ap_need;
  logic        spacing_ok;
  logic [5:0]  mrd_cnt_q;
  logic        all_idle;
  logic        cke_ok;
  logic        exec;
  logic        target_ok;
  logic        accept;
  logic [3:0]  legal_v;
  logic [3:0]  idle_v;

  bank_cmd_if bif [4] ();

  // two-stage sync of every pin but address bit 13; bundling keeps all lines aligned to the same edge
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      pin_s1_q <= 21'h1f0000;
      pin_s2_q <= 21'h1f0000;
      ck_s3_q  <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {cs_n_in, ras_n_in, cas_n_in, we_n_in, cke_in, ddr_ck_in, ba_in, addr_in[12:0]};
      pin_s2_q <= pin_s1_q;
      ck_s3_q  <= pin_s2_q[15];
    end
  end

  // address bit 13 is unused by this density; row width kept at fourteen with top bit zero
  assign cs_n = pin_s2_q[20];
  assign rcw  = pin_s2_q[19:17];
  assign cke  = pin_s2_q[16];
  assign tick = pin_s2_q[15] && !ck_s3_q;                                  // see R01
  assign ba   = pin_s2_q[14:13];
  assign addr = {1'b0, pin_s2_q[12:0]};

  // command decode; reserved pattern counts as nop
  always_comb
  begin
    if (cs_n)
      cmd = CMD_DES;                                                       // see R02
    else
    begin
      case (rcw)                                                           // see R04
        3'b011:  cmd = CMD_ACT;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b010:  cmd = CMD_PRE;
        3'b001:  cmd = CMD_REF;
        3'b000:  cmd = CMD_MRS;
        default: cmd = CMD_NOP;                                            // see R03
      endcase
    end
  end

  // cke history sampled only on link edges
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      cke_prev_q <= 1'b0;
    else if (tick)
      cke_prev_q <= cke;
  end

  assign cke_ok = cke && cke_prev_q;                                       // see R05
  assign wl      = mr_q[0][`CL_MSB:`CL_LSB] - 3'h1;
  assign bl_half = (mr_q[0][`BL_MSB:`BL_LSB] == `BL8_CODE) ? 3'h4 : 3'h2;

  // bank trackers, one per bank
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_bank
      assign bif[g].tick    = tick;
      assign bif[g].valid   = accept && (ba == 2'(g) || (cmd == CMD_PRE && addr[`AP_BIT]));
      assign bif[g].cmd     = cmd;
      assign bif[g].ap      = addr[`AP_BIT];
      assign bif[g].row     = addr;
      assign bif[g].wl      = wl;
      assign bif[g].bl_half = bl_half;
      assign legal_v[g]     = bif[g].legal;
      assign idle_v[g]      = (bif[g].state == BK_IDLE);
      assign bank_state_out[3*g +: 3] = bif[g].state;
      assign bank_row_out[14*g +: 14] = bif[g].row_q;
      bank_tracker u_bank (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .bif        (bif[g])
      );
    end
  endgenerate

  assign all_idle = &idle_v;

  // least spacing after an auto-precharge access in another bank
  always_comb
  begin
    ap_need = 6'h01;                                                       // see R18
    if (ap_kind_q == AP_WR)
    begin
      if (cmd == CMD_RD)
        ap_need = {3'h0, wl} + {3'h0, bl_half} + `WTR_CK;                  // see R16
      else if (cmd == CMD_WR)
        ap_need = {3'h0, bl_half};                                         // see R17
    end
    else if (ap_kind_q == AP_RD)
    begin
      if (cmd == CMD_RD)
        ap_need = {3'h0, bl_half};                                         // see R18
      else if (cmd == CMD_WR)
        ap_need = {3'h0, bl_half} + `AP2WR_EXTRA;                          // see R17
    end
  end

  assign spacing_ok = (ap_kind_q == AP_NONE) || (ap_bank_q == ba) || (ap_cnt_q + 6'h01 >= ap_need); // see R15

  // target check: precharge-all needs every bank fit, refresh and mode load every bank idle, others only the addressed one
  always_comb
  begin
    case (cmd)
      CMD_REF,
      CMD_MRS: target_ok = all_idle;                                       // see R12
      CMD_PRE: target_ok = addr[`AP_BIT] ? &legal_v : legal_v[ba];
      default: target_ok = legal_v[ba];                                    // see R06 R07
    endcase
  end

  assign exec   = tick && cke_ok && cmd != CMD_DES && cmd != CMD_NOP;      // see R02 R03 R05
  assign accept = exec && target_ok && spacing_ok && mrd_cnt_q <= 6'h01;   // see R25 R20

  // tracker of the last auto-precharge access, counted in link edges
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      ap_kind_q <= AP_NONE;
      ap_bank_q <= 2'h0;
      ap_cnt_q  <= 6'h00;
    end
    else if (accept && (cmd == CMD_RD || cmd == CMD_WR) && addr[`AP_BIT])
    begin
      ap_kind_q <= (cmd == CMD_RD) ? AP_RD : AP_WR;                        // see R24
      ap_bank_q <= ba;
      ap_cnt_q  <= 6'h00;
    end
    else if (tick && ap_cnt_q != 6'h3e)
      ap_cnt_q <= ap_cnt_q + 6'h01;                                        // stops one short so count plus one never wraps
  end

  // mode-register set delay
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mrd_cnt_q <= 6'h00;
    else if (accept && cmd == CMD_MRS)
      mrd_cnt_q <= `MRD_CK;
    else if (tick && mrd_cnt_q != 6'h00)
      mrd_cnt_q <= mrd_cnt_q - 6'h01;
  end

  // mode registers; bank inputs pick which one is loaded
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 4; i++)
        mr_q[i] <= (i == 0) ? `MR_RST : 14'h0000;
    end
    else if (accept && cmd == CMD_MRS)
      mr_q[ba] <= addr;                                                    // see R19
  end

  // registered outcome of each link edge carrying an executable command
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      cmd_code_out   <= CMD_NOP;
      cmd_accept_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      cmd_bank_out   <= 2'h0;
      mr_wr_out      <= 1'b0;
      mr_sel_out     <= 2'h0;
      mr_data_out    <= 14'h0000;
    end
    else
    begin
      cmd_accept_out <= accept;
      cmd_reject_out <= exec && !accept;
      mr_wr_out      <= accept && cmd == CMD_MRS;
      if (exec)
      begin
        cmd_code_out <= cmd;
        cmd_bank_out <= ba;
      end
      if (accept && cmd == CMD_MRS)
      begin
        mr_sel_out  <= ba;
        mr_data_out <= addr;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_deselect_ignored: assert property (tick && cs_n |=> !cmd_accept_out && !cmd_reject_out) // see R02
    else $error("deselect produced a command");
  a_nop_ignored: assert property (tick && !cs_n && rcw == 3'b111 |=> !cmd_accept_out) // see R03
    else $error("nop produced a command");
  a_cke_gate: assert property (tick && !(cke && cke_prev_q) |=> !cmd_accept_out && !cmd_reject_out) // see R05
    else $error("command taken with cke low");
  a_other_bank: assert property (exec && spacing_ok && mrd_cnt_q <= 6'h01 // see R07
    && (cmd == CMD_ACT && idle_v[ba] || cmd inside {CMD_RD, CMD_WR} && bank_state_out[3*ba +: 3] == BK_OPEN)
    |=> cmd_accept_out && cmd_bank_out == $past(ba))
    else $error("permitted other-bank command refused");
  a_decode_read: assert property (exec && !cs_n && rcw == 3'b101 |=> cmd_code_out == CMD_RD) // see R04
    else $error("read decoded wrongly");
  a_mode_write: assert property (accept && cmd == CMD_MRS // see R19
    |=> mr_wr_out && mr_sel_out == $past(ba) && mr_data_out == $past(addr))
    else $error("mode load went to the wrong register");
  a_wrap_spacing: assert property (ap_kind_q == AP_WR && ap_bank_q != ba && cmd == CMD_WR && exec // see R15
    && ap_cnt_q + 6'h01 < {3'h0, bl_half} |=> cmd_reject_out)
    else $error("write too close to write with auto precharge");
  a_idle_accept: assert property (exec && cmd == CMD_ACT && idle_v[ba] && spacing_ok && mrd_cnt_q <= 6'h01 // see R06
    |=> cmd_accept_out)
    else $error("activate to idle bank refused");
  c_mode_load: cover property (mr_wr_out);
  c_reject: cover property (cmd_reject_out);
  c_concurrent: cover property (accept && ap_kind_q != AP_NONE && ap_bank_q != ba);
endmodule // ddr2_cmd_interp
`default_nettype wire

/* test/ddr2_ctrl_model.sv */
// behavioural memory controller that drives the command pins of the interpreter
`default_nettype none
module ddr2_ctrl_model
  import ddr2_cmd_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  output logic             ddr_ck_out,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic             cke_out,
  output logic [1:0]       ba_out,
  output logic [13:0]      addr_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // link clock stands low in reset, then runs free; the odd offset keeps its edges off the system edges
  initial
  begin
    ddr_ck_out = 1'b0;
    #3;
    forever
    begin
      #62.5;
      ddr_ck_out = sys_rst_in ? 1'b0 : ~ddr_ck_out;
    end
  end

  // idle pins at time zero
  initial
  begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h7;
    cke_out = 1'b1;
    ba_out = 2'h0;
    addr_out = 14'h0000;
  end

  // select, ras, cas, we levels of each command; deselect carries an activate shape to prove it is ignored
  function automatic logic [3:0] pins_of(input cmd_t c);
    case (c)
      CMD_ACT: pins_of = 4'h3;
      CMD_RD:  pins_of = 4'h5;
      CMD_WR:  pins_of = 4'h4;
      CMD_PRE: pins_of = 4'h2;
      CMD_REF: pins_of = 4'h1;
      CMD_MRS: pins_of = 4'h0;
      CMD_DES: pins_of = 4'hb;
      default: pins_of = 4'h7;
    endcase
  endfunction

  // one command per link edge: pins move just after the falling edge, half a period clear of the rise
  task automatic link_edge(input cmd_t c, input logic [1:0] b, input logic [13:0] a);
    @(posedge clk_sys_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= pins_of(c);
    if (c == CMD_NOP || c == CMD_DES)
    begin
      // a don't-care bus never shows the last value
      addr_out <= ~addr_out;
      ba_out <= ~ba_out;
    end
    else
    begin
      addr_out <= a;
      ba_out <= b;
    end
    @(posedge ddr_ck_out);
    @(negedge ddr_ck_out);
  endtask

  // clock enable changes in the low phase as well
  task automatic set_cke(input logic v);
    @(posedge clk_sys_in);
    cke_out <= v;
  endtask
endmodule // ddr2_ctrl_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the command interpreter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ddr2_cmd_pkg::*;

  logic        clk_sys_in;
  logic        sys_rst_in;
  logic        ddr_ck;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        cke;
  logic [1:0]  ba;
  logic [13:0] addr;
  cmd_t        cmd_code;
  logic        acc;
  logic        rej;
  logic        mr_wr;
  logic [1:0]  cmd_bank;
  logic [1:0]  mr_sel;
  logic [13:0] mr_data;
  logic [11:0] bst;
  logic [55:0] brow;
  int          err_count = 0;
  int          checked = 0;
  int          acc_n = 0;
  int          rej_n = 0;
  int          mrw_n = 0;

  ddr2_cmd_interp i_ddr2_cmd_interp (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ddr_ck_in(ddr_ck),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .cke_in(cke), .ba_in(ba),
    .addr_in(addr), .cmd_code_out(cmd_code), .cmd_accept_out(acc), .cmd_reject_out(rej),
    .cmd_bank_out(cmd_bank), .mr_wr_out(mr_wr), .mr_sel_out(mr_sel), .mr_data_out(mr_data),
    .bank_state_out(bst), .bank_row_out(brow));

  ddr2_ctrl_model i_ddr2_ctrl_model (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ddr_ck_out(ddr_ck),
    .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .cke_out(cke), .ba_out(ba),
    .addr_out(addr));

  // system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // pulses stand one cycle, so they are counted here rather than sampled by the scenarios
  always @(posedge clk_sys_in)
  begin
    if (acc === 1'b1) acc_n <= acc_n + 1;
    if (rej === 1'b1) rej_n <= rej_n + 1;
    if (mr_wr === 1'b1) mrw_n <= mrw_n + 1;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // one link edge, then the pulses it caused are judged
  task automatic step(input cmd_t c, input logic [1:0] b, input logic [13:0] a, input bit ea, input bit er);
    int a0;
    int r0;
    a0 = acc_n;
    r0 = rej_n;
    i_ddr2_ctrl_model.link_edge(c, b, a);
    chk((acc_n - a0) == int'(ea), $sformatf("accept count after %s", c.name()));
    chk((rej_n - r0) == int'(er), $sformatf("reject count after %s", c.name()));
    if (ea)
      chk(cmd_code === c && cmd_bank === b, "command code or bank");
  endtask

  task automatic nops(input int n);
    repeat (n) step(CMD_NOP, 2'h0, 14'h0000, 1'b0, 1'b0);
  endtask

  task automatic st(input int g, input bank_state_t e, input string m);
    chk(bst[3*g +: 3] === e, m);
  endtask

  task automatic s_reset();
    chk(bst === 12'h000 && brow === 56'h0 && cmd_code === CMD_NOP, "reset values");
    chk(acc === 1'b0 && rej === 1'b0 && mr_wr === 1'b0, "reset pulses");
    nops(3);
  endtask

  task automatic s_decode();
    step(CMD_ACT, 2'h1, 14'h0005, 1'b1, 1'b0);
    st(1, BK_ACTV, "activate state");
    nops(2);
    st(1, BK_ACTV, "activate delay too short");
    nops(1);
    st(1, BK_OPEN, "row active after delay");
    chk(brow[27:14] === 14'h0005, "open row");
    step(CMD_RD, 2'h1, 14'h0000, 1'b1, 1'b0);
    st(1, BK_READ, "read state");
    nops(4);
    step(CMD_PRE, 2'h1, 14'h0000, 1'b1, 1'b0);
    nops(2);
    st(1, BK_PRE, "precharge time too short");
    nops(1);
    st(1, BK_IDLE, "idle after precharge");
  endtask

  task automatic s_ignore();
    step(CMD_DES, 2'h0, 14'h0007, 1'b0, 1'b0);
    st(0, BK_IDLE, "deselect changed bank");
    i_ddr2_ctrl_model.set_cke(1'b0);
    step(CMD_ACT, 2'h0, 14'h0007, 1'b0, 1'b0);
    i_ddr2_ctrl_model.set_cke(1'b1);
    step(CMD_ACT, 2'h0, 14'h0007, 1'b0, 1'b0);
    step(CMD_RD, 2'h0, 14'h0000, 1'b0, 1'b1);
    step(CMD_ACT, 2'h0, 14'h0007, 1'b1, 1'b0);
    nops(3);
  endtask

  task automatic s_mode();
    int m0;
    step(CMD_MRS, 2'h0, 14'h0032, 1'b0, 1'b1);
    step(CMD_PRE, 2'h0, 14'h0400, 1'b1, 1'b0);
    nops(3);
    chk(bst === 12'h000, "precharge all");
    step(CMD_REF, 2'h0, 14'h0000, 1'b1, 1'b0);
    m0 = mrw_n;
    step(CMD_MRS, 2'h2, 14'h1234, 1'b1, 1'b0);
    chk(mrw_n - m0 == 1 && mr_sel === 2'h2 && mr_data === 14'h1234, "mode load");
    step(CMD_ACT, 2'h0, 14'h0009, 1'b0, 1'b1);
    step(CMD_ACT, 2'h0, 14'h0009, 1'b1, 1'b0);
    step(CMD_ACT, 2'h1, 14'h0011, 1'b1, 1'b0);
    step(CMD_ACT, 2'h2, 14'h0003, 1'b1, 1'b0);
    step(CMD_ACT, 2'h3, 14'h0004, 1'b1, 1'b0);
    nops(3);
    chk(bst === {BK_OPEN, BK_OPEN, BK_OPEN, BK_OPEN}, "all banks open");
    chk(brow === {14'h0004, 14'h0003, 14'h0011, 14'h0009}, "open rows");
  endtask

  task automatic s_read_ap();
    step(CMD_RD, 2'h0, 14'h0400, 1'b1, 1'b0);
    st(0, BK_RDAP, "read with auto precharge");
    step(CMD_RD, 2'h2, 14'h0000, 1'b0, 1'b1);
    st(0, BK_RDAP, "read access period");
    step(CMD_WR, 2'h2, 14'h0000, 1'b0, 1'b1);
    st(0, BK_PRE, "auto precharge start");
    nops(1);
    step(CMD_WR, 2'h2, 14'h0000, 1'b1, 1'b0);
    st(2, BK_WRITE, "write during auto precharge");
    nops(1);
    st(0, BK_IDLE, "idle after auto precharge");
  endtask

  task automatic s_write_ap();
    nops(6);
    st(2, BK_OPEN, "write burst over");
    step(CMD_WR, 2'h2, 14'h0400, 1'b1, 1'b0);
    step(CMD_WR, 2'h1, 14'h0000, 1'b0, 1'b1);
    st(1, BK_OPEN, "refused command left bank alone");
    step(CMD_PRE, 2'h1, 14'h0000, 1'b1, 1'b0);
    nops(2);
    step(CMD_RD, 2'h3, 14'h0000, 1'b0, 1'b1);
    step(CMD_RD, 2'h3, 14'h0000, 1'b1, 1'b0);
    st(3, BK_READ, "read beside auto precharge");
    st(2, BK_WRAP, "write recovery still running");
    nops(1);
    st(2, BK_PRE, "precharge after write recovery");
    nops(3);
    st(2, BK_IDLE, "idle after write auto precharge");
  endtask

  // main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(negedge ddr_ck);
    s_reset();
    s_decode();
    s_ignore();
    s_mode();
    s_read_ap();
    s_write_ap();
    test_done();
  end

  // a hang counts as a mismatch and still reaches the report
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    $display("[FAIL] %0t run limit reached", $time);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
